// ---- verilog/ballast_fault_pkg.sv ----
// Constants and types for the ballast fault protection manager.
// Assumes a single 250 MHz clock; all comparator inputs arrive asynchronously.
// How it works
// [R01] Monitoring: supply below start threshold 1us blocks power-up.
// [R02] Supply below lockout 5us: power down, clear latch.
// [R03] Monitoring: either high-side filament open 100us blocks.
// [R04] Monitoring: low-side sense above 1.6V 100us blocks.
// [R05] Run: low-side above 3.2V 620us latches fault.
// [R06] Power-up: bus below 12.5% 1us, drives off, hysteresis.
// [R07] Active: bus below 12.5% stops PFC, no fault.
// [R08] Run: bus below 12.5% 625ms, restart when recovered.
// [R09] Run: bus below 75%, 100ms wait, skip preheat, max 7.
// [R10] Start-up: bus below 95% 80ms, 200ms restart.
// [R11] Power-up: bus above 105% 5us, drives off, hysteresis.
// [R12] Active: bus above 109% 5us stops PFC until <105%.
// [R13] Run: bus above 109% 625ms, restart below 105%.
// [R14] Run: lamp peak overvoltage 620us latches fault.
// [R15] Run: lamp rectifying effect 2500ms latches fault.
// [R16] Latched fault: wait 200ms, one restart, second latches.
// [R17] Failure latch clears at lockout or 40s run.
// [R18] Conditions must persist continuously; glitches restart timers.
// [R19] Each check enabled only in its listed phases.
package ballast_fault_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned T_START_US = 1;
  localparam int unsigned T_UVLO_US = 5;
  localparam int unsigned T_FIL_US = 100;
  localparam int unsigned T_FAULT_US = 620;
  localparam int unsigned T_OPEN_US = 1;
  localparam int unsigned T_OV_US = 5;
  localparam int unsigned T_UV_US = 84;
  localparam int unsigned T_UV_DELAY_US = 120;
  localparam int unsigned T_LONG_MS = 625;
  localparam int unsigned T_STARTUP_MS = 80;
  localparam int unsigned T_RETRY_MS = 200;
  localparam int unsigned T_UV_WAIT_MS = 100;
  localparam int unsigned T_RECT_MS = 2500;
  localparam int unsigned T_CLEAR_S = 40;
  localparam logic [3:0] UV_RESTART_MAX = 4'h7;

  localparam int unsigned CYC_START = T_START_US * CLK_MHZ;
  localparam int unsigned CYC_UVLO = T_UVLO_US * CLK_MHZ;
  localparam int unsigned CYC_FIL = T_FIL_US * CLK_MHZ;
  localparam int unsigned CYC_FAULT = T_FAULT_US * CLK_MHZ;
  localparam int unsigned CYC_OPEN = T_OPEN_US * CLK_MHZ;
  localparam int unsigned CYC_OV = T_OV_US * CLK_MHZ;
  localparam int unsigned CYC_UV = (T_UV_US + T_UV_DELAY_US) * CLK_MHZ;
  localparam int unsigned CYC_LONG = T_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned CYC_STARTUP = T_STARTUP_MS * 1000 * CLK_MHZ;
  localparam int unsigned CYC_RETRY = T_RETRY_MS * 1000 * CLK_MHZ;
  localparam int unsigned CYC_UV_WAIT = T_UV_WAIT_MS * 1000 * CLK_MHZ;
  localparam longint unsigned CYC_RECT = longint'(T_RECT_MS) * 1000 * CLK_MHZ;
  localparam longint unsigned CYC_CLEAR = longint'(T_CLEAR_S) * 1000000 * CLK_MHZ;

  localparam int unsigned NUM_CHK = 14;
  localparam int unsigned CNT_W = 40;

  // Check indices into the qualifier array.
  localparam int unsigned C_START = 0;
  localparam int unsigned C_UVLO = 1;
  localparam int unsigned C_HS1 = 2;
  localparam int unsigned C_HS2 = 3;
  localparam int unsigned C_LS_MON = 4;
  localparam int unsigned C_LS_RUN = 5;
  localparam int unsigned C_OPEN_PU = 6;
  localparam int unsigned C_OPEN = 7;
  localparam int unsigned C_OPEN_LONG = 8;
  localparam int unsigned C_UV = 9;
  localparam int unsigned C_STARTUP = 10;
  localparam int unsigned C_OV_PU = 11;
  localparam int unsigned C_OV = 12;
  localparam int unsigned C_OV_LONG = 13;

  typedef enum logic [2:0] {
    PH_MONITOR = 3'h0,
    PH_POWERUP = 3'h1,
    PH_STARTUP = 3'h2,
    PH_SOFTSTART = 3'h3,
    PH_PREHEAT = 3'h4,
    PH_IGNITION = 3'h5,
    PH_PRERUN = 3'h6,
    PH_RUN = 3'h7
  } phase_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HOLD_OFF = 3'h1,
    ST_WAIT_RETRY = 3'h2,
    ST_WAIT_BUS_LOW = 3'h3,
    ST_WAIT_BUS_HIGH = 3'h4,
    ST_LATCHED = 3'h5
  } action_type;

endpackage : ballast_fault_pkg

// ---- verilog/ballast_fault_protection_manager.sv ----
// Fault qualification and consequence logic of the ballast controller.
// Expects digitised comparator outputs and the current phase from the sequencer.
`timescale 1ns/1ps
module ballast_fault_protection_manager
  import ballast_fault_pkg::*;
#(
  parameter longint unsigned CYC_LONG_P = CYC_LONG,
  parameter longint unsigned CYC_STARTUP_P = CYC_STARTUP,
  parameter longint unsigned CYC_RETRY_P = CYC_RETRY,
  parameter longint unsigned CYC_UV_WAIT_P = CYC_UV_WAIT,
  parameter longint unsigned CYC_RECT_P = CYC_RECT,
  parameter longint unsigned CYC_CLEAR_P = CYC_CLEAR
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Sequencer phase, same clock domain.
  input wire logic [2:0] phase_i,
  // Comparator outcomes, asynchronous.
  input wire logic supply_below_start_i,
  input wire logic supply_below_uvlo_i,
  input wire logic lamp_sense_first_low_i,
  input wire logic lamp_sense_second_low_i,
  input wire logic low_side_filament_sense_above_1v6_i,
  input wire logic low_side_filament_sense_above_3v2_i,
  input wire logic bus_level_below_12p5_i,
  input wire logic bus_level_below_75_i,
  input wire logic bus_level_below_95_i,
  input wire logic bus_level_above_105_i,
  input wire logic bus_level_above_109_i,
  input wire logic lamp_peak_overvoltage_i,
  input wire logic lamp_rectifying_effect_i,
  // Consequences.
  output logic power_up_block_o,
  output logic power_down_o,
  output logic gate_drive_off_o,
  output logic pfc_stop_o,
  output logic skip_preheat_o,
  output logic restart_req_o,
  output logic failure_latch_o,
  output logic latched_fault_o
);

  typedef struct packed {
    logic [NUM_CHK-1:0] s1;
    logic [NUM_CHK-1:0] s2;
    logic [NUM_CHK-1:0][CNT_W-1:0] cnt;
    logic [NUM_CHK-1:0] qual;
    logic [CNT_W-1:0] rect_cnt;
    logic rect_qual;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] run_cnt;
    action_type act;
    logic fail_latch;
    logic [3:0] uv_restarts;
    logic pfc_hold_ov;
    logic skip_pre;
    logic restart;
    logic [1:0] aux_s1;
    logic [1:0] aux_s2;
    logic [CNT_W-1:0] peak_cnt;
    logic peak_qual;
  } state_type;

  logic rst_meta_ff;
  logic rst_sync_ff;
  state_type cur_ff;
  state_type nxt_cur;
  logic [NUM_CHK-1:0] raw;
  logic [NUM_CHK-1:0] en;
  logic [NUM_CHK-1:0][CNT_W-1:0] lim;
  phase_type ph;
  logic active;
  logic [CNT_W-1:0] wait_lim;

  // Reset release synchroniser.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign ph = phase_type'(phase_i);
  assign active = (ph != PH_MONITOR) && (ph != PH_POWERUP);

  assign raw = {bus_level_above_109_i, bus_level_above_109_i, bus_level_above_105_i,
                bus_level_below_95_i, bus_level_below_75_i, bus_level_below_12p5_i,
                bus_level_below_12p5_i, bus_level_below_12p5_i, low_side_filament_sense_above_3v2_i,
                low_side_filament_sense_above_1v6_i, lamp_sense_second_low_i, lamp_sense_first_low_i,
                supply_below_uvlo_i, supply_below_start_i};

  // Phase gating per check.
  always_comb begin
    en = '0;
    en[C_START] = (ph == PH_MONITOR); // [R01] [R19]
    en[C_UVLO] = 1'b1; // [R02] [R19]
    en[C_HS1] = (ph == PH_MONITOR); // [R03] [R19]
    en[C_HS2] = (ph == PH_MONITOR); // [R03] [R19]
    en[C_LS_MON] = (ph == PH_MONITOR); // [R04] [R19]
    en[C_LS_RUN] = (ph == PH_RUN); // [R05] [R19]
    en[C_OPEN_PU] = (ph == PH_POWERUP); // [R06] [R19]
    en[C_OPEN] = active; // [R07] [R19]
    en[C_OPEN_LONG] = (ph == PH_RUN); // [R08] [R19]
    en[C_UV] = (ph == PH_RUN); // [R09] [R19]
    en[C_STARTUP] = (ph == PH_STARTUP); // [R10] [R19]
    en[C_OV_PU] = (ph == PH_POWERUP); // [R11] [R19]
    en[C_OV] = active; // [R12] [R19]
    en[C_OV_LONG] = (ph == PH_RUN); // [R13] [R19]
  end

  always_comb begin
    lim[C_START] = CNT_W'(CYC_START);
    lim[C_UVLO] = CNT_W'(CYC_UVLO);
    lim[C_HS1] = CNT_W'(CYC_FIL);
    lim[C_HS2] = CNT_W'(CYC_FIL);
    lim[C_LS_MON] = CNT_W'(CYC_FIL);
    lim[C_LS_RUN] = CNT_W'(CYC_FAULT);
    lim[C_OPEN_PU] = CNT_W'(CYC_OPEN);
    lim[C_OPEN] = CNT_W'(CYC_OPEN);
    lim[C_OPEN_LONG] = CNT_W'(CYC_LONG_P);
    lim[C_UV] = CNT_W'(CYC_UV);
    lim[C_STARTUP] = CNT_W'(CYC_STARTUP_P);
    lim[C_OV_PU] = CNT_W'(CYC_OV);
    lim[C_OV] = CNT_W'(CYC_OV);
    lim[C_OV_LONG] = CNT_W'(CYC_LONG_P);
  end

  always_comb begin
    case (cur_ff.act)
      ST_WAIT_RETRY: wait_lim = cur_ff.skip_pre ? CNT_W'(CYC_UV_WAIT_P) : CNT_W'(CYC_RETRY_P);
      default: wait_lim = CNT_W'(CYC_RETRY_P);
    endcase
  end

  always_comb begin
    logic latch_evt;
    latch_evt = 1'b0;
    nxt_cur = cur_ff;
    nxt_cur.s1 = raw;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.aux_s1 = {lamp_peak_overvoltage_i, lamp_rectifying_effect_i};
    nxt_cur.aux_s2 = cur_ff.aux_s1;
    nxt_cur.restart = 1'b0;
    // Any drop in a condition restarts its timer, so only continuous faults qualify.
    for (int i = 0; i < NUM_CHK; i++) begin
      if (!cur_ff.s2[i] || !en[i]) begin // [R18]
        nxt_cur.cnt[i] = '0;
        nxt_cur.qual[i] = 1'b0;
      end else if (cur_ff.cnt[i] < lim[i]) begin
        nxt_cur.cnt[i] = cur_ff.cnt[i] + CNT_W'(1);
        nxt_cur.qual[i] = (cur_ff.cnt[i] + CNT_W'(1)) >= lim[i];
      end
    end
    // The lamp voltage checks sit outside the indexed array, so each keeps its own timer.
    if (!(cur_ff.aux_s2[0] && ph == PH_RUN)) begin // [R15] [R18]
      nxt_cur.rect_cnt = '0;
      nxt_cur.rect_qual = 1'b0;
    end else if (cur_ff.rect_cnt < CNT_W'(CYC_RECT_P)) begin
      nxt_cur.rect_cnt = cur_ff.rect_cnt + CNT_W'(1);
      nxt_cur.rect_qual = (cur_ff.rect_cnt + CNT_W'(1)) >= CNT_W'(CYC_RECT_P);
    end
    if (!(cur_ff.aux_s2[1] && ph == PH_RUN)) begin // [R14] [R18] [R19]
      nxt_cur.peak_cnt = '0;
      nxt_cur.peak_qual = 1'b0;
    end else if (cur_ff.peak_cnt < CNT_W'(CYC_FAULT)) begin
      nxt_cur.peak_cnt = cur_ff.peak_cnt + CNT_W'(1);
      nxt_cur.peak_qual = (cur_ff.peak_cnt + CNT_W'(1)) >= CNT_W'(CYC_FAULT);
    end
    // PFC overvoltage hold releases below the lower band or outside the active phases.
    if (cur_ff.qual[C_OV]) begin
      nxt_cur.pfc_hold_ov = 1'b1; // [R12]
    end else if (!cur_ff.s2[C_OV_PU] || !active) begin
      nxt_cur.pfc_hold_ov = 1'b0;
    end
    // Forty seconds of clean run mode forgives an earlier fault.
    if (ph == PH_RUN && cur_ff.act == ST_IDLE) begin
      nxt_cur.run_cnt = (cur_ff.run_cnt < CNT_W'(CYC_CLEAR_P)) ? cur_ff.run_cnt + CNT_W'(1) : cur_ff.run_cnt;
      if (cur_ff.run_cnt + CNT_W'(1) >= CNT_W'(CYC_CLEAR_P)) begin
        nxt_cur.fail_latch = 1'b0; // [R17]
        nxt_cur.uv_restarts = '0;
      end
    end else begin
      nxt_cur.run_cnt = '0;
    end
    latch_evt = cur_ff.qual[C_LS_RUN] || cur_ff.rect_qual || cur_ff.peak_qual; // [R05] [R14] [R15]
    case (cur_ff.act)
      ST_IDLE: begin
        nxt_cur.wait_cnt = '0;
        if (cur_ff.qual[C_OPEN_PU] || cur_ff.qual[C_OV_PU]) begin
          nxt_cur.act = ST_HOLD_OFF; // [R06] [R11]
        end else if (latch_evt) begin
          if (cur_ff.fail_latch) begin
            nxt_cur.act = ST_LATCHED; // [R16]
          end else begin
            nxt_cur.fail_latch = 1'b1; // [R05] [R14] [R15]
            nxt_cur.skip_pre = 1'b0;
            nxt_cur.act = ST_WAIT_RETRY;
          end
        end else if (cur_ff.qual[C_OPEN_LONG]) begin
          nxt_cur.act = ST_WAIT_BUS_HIGH; // [R08]
        end else if (cur_ff.qual[C_OV_LONG]) begin
          nxt_cur.act = ST_WAIT_BUS_LOW; // [R13]
        end else if (cur_ff.qual[C_UV]) begin
          if (cur_ff.uv_restarts >= UV_RESTART_MAX) begin
            nxt_cur.act = ST_LATCHED; // [R09]
          end else begin
            nxt_cur.uv_restarts = cur_ff.uv_restarts + 4'h1;
            nxt_cur.skip_pre = 1'b1;
            nxt_cur.act = ST_WAIT_RETRY;
          end
        end else if (cur_ff.qual[C_STARTUP]) begin
          nxt_cur.skip_pre = 1'b0; // [R10]
          nxt_cur.act = ST_WAIT_RETRY;
        end
      end
      ST_WAIT_RETRY: begin
        nxt_cur.wait_cnt = cur_ff.wait_cnt + CNT_W'(1);
        if (cur_ff.wait_cnt + CNT_W'(1) >= wait_lim) begin
          nxt_cur.restart = 1'b1; // [R09] [R10] [R16]
          nxt_cur.act = ST_IDLE;
        end
      end
      ST_WAIT_BUS_HIGH: begin
        if (!cur_ff.s2[C_OPEN]) begin
          nxt_cur.restart = 1'b1; // [R08]
          nxt_cur.act = ST_IDLE;
        end
      end
      ST_WAIT_BUS_LOW: begin
        if (!cur_ff.s2[C_OV_PU]) begin
          nxt_cur.restart = 1'b1; // [R13]
          nxt_cur.act = ST_IDLE;
        end
      end
      default: begin
        // Hold-off and latched states leave only through supply lockout.
        nxt_cur.act = cur_ff.act;
      end
    endcase
    // Supply lockout overrides everything and clears the failure latch.
    if (cur_ff.qual[C_UVLO]) begin
      nxt_cur.act = ST_IDLE; // [R02] [R17]
      nxt_cur.fail_latch = 1'b0;
      nxt_cur.uv_restarts = '0;
      nxt_cur.skip_pre = 1'b0;
      nxt_cur.restart = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign power_up_block_o = cur_ff.qual[C_START] | cur_ff.qual[C_HS1] | cur_ff.qual[C_HS2] |
                            cur_ff.qual[C_LS_MON]; // [R01] [R03] [R04]
  assign power_down_o = cur_ff.qual[C_UVLO] | (cur_ff.act != ST_IDLE);
  assign gate_drive_off_o = power_down_o;
  assign pfc_stop_o = cur_ff.qual[C_OPEN] | cur_ff.pfc_hold_ov | power_down_o; // [R07] [R12]
  assign skip_preheat_o = cur_ff.skip_pre;
  assign restart_req_o = cur_ff.restart;
  assign failure_latch_o = cur_ff.fail_latch;
  assign latched_fault_o = (cur_ff.act == ST_LATCHED);

endmodule : ballast_fault_protection_manager

// ---- dv/ballast_fault_monitor.sv ----
// Concurrent checks on the ports of the ballast fault protection manager.
// Assumes the bind at the foot of this file attaches it to every manager instance.
`timescale 1ns/1ps
module ballast_fault_monitor
  import ballast_fault_pkg::*;
#(
  parameter longint unsigned CYC_RECT_P = CYC_RECT
) (
  // Clock, reset and phase.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] phase_i,
  // Conditions watched.
  input wire logic supply_below_start_i,
  input wire logic supply_below_uvlo_i,
  input wire logic lamp_sense_first_low_i,
  input wire logic bus_level_below_12p5_i,
  input wire logic bus_level_above_109_i,
  input wire logic lamp_rectifying_effect_i,
  // Consequences.
  input wire logic power_up_block_o,
  input wire logic power_down_o,
  input wire logic gate_drive_off_o,
  input wire logic pfc_stop_o,
  input wire logic restart_req_o,
  input wire logic failure_latch_o,
  input wire logic latched_fault_o
);
  logic [5:0] cond;
  logic [39:0] run_cnt [6];

  // Counters see the raw inputs, so a margin of 8 cycles covers synchroniser and reset lag.
  assign cond = {lamp_rectifying_effect_i && phase_i == PH_RUN, bus_level_below_12p5_i && phase_i >= 3'h2,
    bus_level_above_109_i && phase_i >= 3'h2, lamp_sense_first_low_i && phase_i == PH_MONITOR,
    supply_below_uvlo_i, supply_below_start_i && phase_i == PH_MONITOR};

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int k = 0; k < 6; k++) begin
        run_cnt[k] <= 40'h0;
      end
    end else begin
      for (int k = 0; k < 6; k++) begin
        run_cnt[k] <= cond[k] ? run_cnt[k] + 40'h1 : 40'h0;
      end
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_gate_follows_down: assert property (gate_drive_off_o == power_down_o)
    else $error("gate drive off differs from power down");
  a_start_blocks: assert property (run_cnt[0] == 40'(CYC_START + 8) |-> power_up_block_o)
    else $error("low supply did not block power up");
  a_lockout_down: assert property (run_cnt[1] == 40'(CYC_UVLO + 8) |-> power_down_o && !failure_latch_o && !latched_fault_o)
    else $error("lockout did not power down and clear latch");
  a_filament_blocks: assert property (run_cnt[2] == 40'(CYC_FIL + 8) |-> power_up_block_o)
    else $error("open filament did not block power up");
  a_overvolt_pfc: assert property (run_cnt[3] == 40'(CYC_OV + 8) |-> pfc_stop_o)
    else $error("bus overvoltage did not stop pfc");
  a_open_loop_pfc: assert property (run_cnt[4] == 40'(CYC_OPEN + 8) |-> pfc_stop_o)
    else $error("open loop did not stop pfc");
  a_rect_latches: assert property (run_cnt[5] == 40'(CYC_RECT_P + 8) |-> power_down_o && (failure_latch_o || latched_fault_o))
    else $error("rectifying effect did not latch a fault");
  a_no_block_run: assert property ((phase_i == PH_RUN) [*8] |-> !power_up_block_o)
    else $error("power up block seen in run phase");
  a_restart_pulse: assert property (restart_req_o |=> !restart_req_o)
    else $error("restart request longer than one cycle");

  c_restart: cover property (restart_req_o);
  c_latched: cover property ($rose(latched_fault_o));
  c_pfc_only: cover property (pfc_stop_o && !power_down_o);
endmodule : ballast_fault_monitor

bind ballast_fault_protection_manager ballast_fault_monitor #(.CYC_RECT_P(CYC_RECT_P)) i_ballast_fault_monitor (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .phase_i(phase_i),
  .supply_below_start_i(supply_below_start_i), .supply_below_uvlo_i(supply_below_uvlo_i),
  .lamp_sense_first_low_i(lamp_sense_first_low_i), .bus_level_below_12p5_i(bus_level_below_12p5_i),
  .bus_level_above_109_i(bus_level_above_109_i), .lamp_rectifying_effect_i(lamp_rectifying_effect_i),
  .power_up_block_o(power_up_block_o), .power_down_o(power_down_o), .gate_drive_off_o(gate_drive_off_o),
  .pfc_stop_o(pfc_stop_o), .restart_req_o(restart_req_o), .failure_latch_o(failure_latch_o),
  .latched_fault_o(latched_fault_o));

// ---- dv/ballast_fault_protection_manager_tb_top.sv ----
// Self-checking bench for the ballast fault protection manager.
// Assumes the package, the manager and its bound checker are compiled first.
`timescale 1ns/1ps
module ballast_fault_protection_manager_tb_top
  import ballast_fault_pkg::*;
;
  typedef struct {
    phase_type ph;
    logic [12:0] cond;
    int hold;
    logic [7:0] mask;
    logic [7:0] exp;
  } row_type;

  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] phase_i = 3'h0;
  logic [12:0] cin = 13'h0000;
  wire [7:0] outs;
  int mismatches;
  int checks;
  // Condition bits: 12 start, 11 lockout, 10 and 9 hs filament, 8 ls >1.6V, 7 ls >3.2V, 6 bus <12.5%, 5 <75%,
  // 4 <95%, 3 >105%, 2 >109%, 1 lamp peak, 0 rect.
  row_type rows [13] = '{
    '{PH_MONITOR, 13'h1000, 270, 8'h80, 8'h80},
    '{PH_RUN, 13'h1000, 300, 8'h80, 8'h00},
    '{PH_MONITOR, 13'h0400, 25020, 8'h80, 8'h80},
    '{PH_POWERUP, 13'h0040, 270, 8'h60, 8'h60},
    '{PH_POWERUP, 13'h0008, 1270, 8'h60, 8'h60},
    '{PH_STARTUP, 13'h0040, 270, 8'h50, 8'h10},
    '{PH_SOFTSTART, 13'h000C, 1270, 8'h50, 8'h10},
    '{PH_RUN, 13'h0040, 500, 8'h40, 8'h40},
    '{PH_RUN, 13'h000C, 1500, 8'h40, 8'h40},
    '{PH_STARTUP, 13'h0010, 180, 8'h4A, 8'h40},
    '{PH_RUN, 13'h0020, 51020, 8'h4A, 8'h48},
    '{PH_MONITOR, 13'h0040, 300, 8'h50, 8'h00},
    '{PH_RUN, 13'h0182, 300, 8'hC0, 8'h00}
  };

  always #2 mclk_i = ~mclk_i;

  // Short counts keep the long timers within a few hundred cycles, except the undervoltage wait, which keeps its full count.
  ballast_fault_protection_manager #(.CYC_LONG_P(200), .CYC_STARTUP_P(150), .CYC_RETRY_P(100),
    .CYC_RECT_P(60), .CYC_CLEAR_P(200)) i_ballast_fault_protection_manager (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .phase_i(phase_i),
    .supply_below_start_i(cin[12]), .supply_below_uvlo_i(cin[11]), .lamp_sense_first_low_i(cin[10]),
    .lamp_sense_second_low_i(cin[9]), .low_side_filament_sense_above_1v6_i(cin[8]),
    .low_side_filament_sense_above_3v2_i(cin[7]), .bus_level_below_12p5_i(cin[6]),
    .bus_level_below_75_i(cin[5]), .bus_level_below_95_i(cin[4]), .bus_level_above_105_i(cin[3]),
    .bus_level_above_109_i(cin[2]), .lamp_peak_overvoltage_i(cin[1]), .lamp_rectifying_effect_i(cin[0]),
    .power_up_block_o(outs[7]), .power_down_o(outs[6]), .gate_drive_off_o(outs[5]), .pfc_stop_o(outs[4]),
    .skip_preheat_o(outs[3]), .restart_req_o(outs[2]), .failure_latch_o(outs[1]), .latched_fault_o(outs[0]));

  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task do_reset();
    reset_n_i = 1'b0;
    cin = 13'h0000;
    phase_i = PH_MONITOR;
    cyc(16);
    reset_n_i = 1'b1;
    cyc(4);
  endtask : do_reset

  task wait_for(input int b, input int lim);
    int n;
    n = 0;
    while (outs[b] !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("unexpected output bit %0d expected 1 seen %b", b, outs[b]);
      end_of_test();
    end
  endtask : wait_for

  // The sequencer leaves run while powered down, so the phase drops to monitoring.
  task rect_fault();
    cin = 13'h0001;
    wait_for(6, 200);
    cyc(10);
    cin = 13'h0000;
    phase_i = PH_MONITOR;
  endtask : rect_fault

  task restart();
    wait_for(2, 200);
    cyc(1);
    check("restart pulse width", outs & 8'h04, 8'h00);
    phase_i = PH_RUN;
  endtask : restart

  initial begin
    mismatches = 0;
    checks = 0;
    do_reset();
    check("outputs after reset", outs, 8'h00);
    foreach (rows[i]) begin
      do_reset();
      phase_i = rows[i].ph;
      cin = rows[i].cond;
      cyc(rows[i].hold);
      check($sformatf("row %0d outputs", i), outs & rows[i].mask, rows[i].exp);
    end
    do_reset();
    cin = 13'h1000;
    cyc(200);
    cin = 13'h0000;
    cyc(1);
    cin = 13'h1000;
    cyc(200);
    check("block after glitch", outs & 8'h80, 8'h00);
    cyc(60);
    check("block after full hold", outs & 8'h80, 8'h80);
    do_reset();
    phase_i = PH_RUN;
    rect_fault();
    check("first fault latch", outs & 8'h03, 8'h02);
    restart();
    cyc(260);
    check("latch after clean run", outs & 8'h02, 8'h00);
    rect_fault();
    restart();
    cin = 13'h0001;
    wait_for(0, 400);
    check("second fault", outs & 8'h41, 8'h41);
    cin = 13'h0800;
    cyc(1300);
    check("lockout clears latches", outs & 8'h43, 8'h40);
    end_of_test();
  end
endmodule : ballast_fault_protection_manager_tb_top
